// *** hw/rmps_pkg.sv ***
package rmps_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
  localparam int CNT_W         = 17;

  // Longest times, rounded down to whole cycles.
  localparam int T_TURN_NS     = 128000;
  localparam int T_STD_RF_NS   = 128000;
  localparam int T_STD_ACT_NS  = 150000;
  localparam int T_PD_STD_NS   = 1500000;
  localparam int T_XT_STD_NS   = 4500000;
  localparam int TURN_CYC      = T_TURN_NS / CLK_PERIOD_NS;
  localparam int STD_RF_CYC    = T_STD_RF_NS / CLK_PERIOD_NS;
  localparam int STD_ACT_CYC   = T_STD_ACT_NS / CLK_PERIOD_NS;
  localparam int START_CYC     = (STD_RF_CYC < STD_ACT_CYC) ?
                                 STD_RF_CYC : STD_ACT_CYC;
  localparam int PD_STD_CYC    = T_PD_STD_NS / CLK_PERIOD_NS;
  localparam int XT_STD_CYC    = T_XT_STD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BOOT_CYC = 2'h3;

  // ------------------------------------------------------------------
  // Host commands
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP     = 3'h0,
    CMD_STANDBY = 3'h1,
    CMD_TX      = 3'h2,
    CMD_RX      = 3'h3,
    CMD_DEEP    = 3'h4,
    CMD_WAKE    = 3'h5,
    CMD_BPM     = 3'h6
  } rmps_cmd_code_t;

  typedef struct packed {
    logic           valid;
    rmps_cmd_code_t code;
  } rmps_cmd_t;

  // Radio core status, same clock domain as the sequencer.
  typedef struct packed {
    logic pkt_sent;
    logic pkt_rcvd;
    logic ack_done;
    logic pll_lock;
  } rmps_rf_sts_t;

  typedef struct packed {
    logic rc_en;
    logic xtal_en;
    logic conv_full;
    logic conv_bangbang;
    logic clk_gate;
    logic vdd_low;
    logic bpm_load;
  } rmps_pwr_t;

  typedef struct packed {
    logic en;
    logic tx;
    logic rx;
    logic ready;
  } rmps_rf_ctl_t;

  localparam rmps_pwr_t PWR_RST = '{rc_en: 1'b1, default: 1'b0};

endpackage

// *** hw/rmps_sync.sv ***
`timescale 1ns/100ps
module rmps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_ff[g] <= 1'b0;
          q_ff[g]    <= 1'b0;
        end else begin
          meta_ff[g] <= d_i[g];
          q_ff[g]    <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign q_o = q_ff;

endmodule

// *** hw/rmps_cmd_link.sv ***
`timescale 1ns/100ps
module rmps_cmd_link (
  input  wire logic                    link_clk_i,
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    host_valid_i,
  input  wire rmps_pkg::rmps_cmd_code_t host_code_i,
  output logic                         host_ready_o,
  output rmps_pkg::rmps_cmd_t          cmd_o
);

  // ------------------------------------------------------------------
  // Link side: toggle request, held code
  // ------------------------------------------------------------------
  // The code stays still until the acknowledge toggle returns, so the
  // core may sample it without a synchroniser of its own.
  logic                     req_ff;
  logic                     ready_ff;
  rmps_pkg::rmps_cmd_code_t code_ff;
  logic                     ack_ff;
  logic                     ack_s;
  logic                     req_s;
  wire                      accept  = host_valid_i & ready_ff;
  wire                      nxt_req = req_ff ^ accept;

  rmps_sync #(.W(1)) u_ack_sync (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (ack_ff),
    .q_o     (ack_s)
  );

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ff   <= 1'b0;
      ready_ff <= 1'b0;
      code_ff  <= rmps_pkg::CMD_NOP;
    end else begin
      req_ff   <= nxt_req;
      ready_ff <= (nxt_req == ack_s);
      if (accept) begin
        code_ff <= host_code_i;
      end
    end
  end

  assign host_ready_o = ready_ff;

  // ------------------------------------------------------------------
  // Core side: one-cycle command pulse
  // ------------------------------------------------------------------
  rmps_pkg::rmps_cmd_t cmd_ff;
  wire                 new_req = (req_s != ack_ff);

  rmps_sync #(.W(1)) u_req_sync (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     (req_ff),
    .q_o     (req_s)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
      cmd_ff <= '{valid: 1'b0, code: rmps_pkg::CMD_NOP};
    end else begin
      ack_ff       <= req_s;
      cmd_ff.valid <= new_req;
      cmd_ff.code  <= new_req ? code_ff : rmps_pkg::CMD_NOP;
    end
  end

  assign cmd_o = cmd_ff;

endmodule

// *** hw/rmps_seq.sv ***
// How it works
// - RX/TX turnaround, same or new channel, ends within 128 us.
// - Standby to transmit or receive ends within 128 us.
// - Power-down to standby bounded at 1.5 ms, waits crystal.
// - Deep mode to normal converter bounded at 4.5 ms.
// - Standby to active radio with settled synthesizer within 150 us.
// - Converter build: RC clocks converter, then crystal, then full regulation.
// - Interrupt output goes to 1 when startup finishes.
// - No-converter build: crystal, interrupt after crystal start, RC stops.
// - After reset standby is the default, only crystal and converter run.
// - Host commands change modes; packet ends change modes automatically.
// - Battery protection switches all off but a load, left only by power.
// - Setting the deep-sleep bit enters the very low consumption mode.
// - Converter deep mode: crystal off, RC with on-off regulation.
// - No-converter power-down: clocks off, digital supply lowered, data kept.
// - Transmit mode sends, then turns to receive for acknowledge if enabled.
// - Transmit only from standby; output ready by programmed start time.
// - Receive mode listens, then turns to transmit to acknowledge.
// - Receive only from standby; reliable after programmed start time.
// - After a transmit and its acknowledge, return to standby.
// - After acknowledging, go back to receiving until host commands standby.
`timescale 1ns/100ps
module rmps_seq #(
  parameter int PD_STD_CYC = rmps_pkg::PD_STD_CYC,
  parameter int XT_STD_CYC = rmps_pkg::XT_STD_CYC
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     link_clk_i,
  input  wire logic                     host_valid_i,
  input  wire rmps_pkg::rmps_cmd_code_t host_code_i,
  output logic                          host_ready_o,
  input  wire logic                     conv_version_i,
  input  wire logic                     supply_ok_i,
  input  wire logic                     xtal_ok_i,
  input  wire logic                     conv_settled_i,
  input  wire logic                     auto_ack_i,
  input  wire logic [7:0]               radio_startup_time_i,
  input  wire rmps_pkg::rmps_rf_sts_t   rf_sts_i,
  output logic                          irq_o,
  output rmps_pkg::rmps_pwr_t           pwr_o,
  output rmps_pkg::rmps_rf_ctl_t        rf_o,
  output logic [3:0]                    mode_o
);

  typedef enum logic [3:0] {
    ST_BOOT, ST_RC_RAMP, ST_XTAL, ST_STANDBY, ST_TX_START, ST_TX,
    ST_TX_TURN, ST_TX_ACK, ST_RX_START, ST_RX, ST_RX_TURN, ST_RX_ACK,
    ST_RX_BACK, ST_DEEP, ST_WAKE, ST_BPM
  } rmps_state_t;

  // ------------------------------------------------------------------
  // Pin synchronisers and host link
  // ------------------------------------------------------------------
  logic [3:0]          pins_s;
  rmps_pkg::rmps_cmd_t cmd;

  rmps_sync #(.W(4)) u_pin_sync (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({conv_version_i, supply_ok_i, xtal_ok_i, conv_settled_i}),
    .q_o     (pins_s)
  );

  rmps_cmd_link u_link (
    .link_clk_i   (link_clk_i),
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .host_valid_i (host_valid_i),
    .host_code_i  (host_code_i),
    .host_ready_o (host_ready_o),
    .cmd_o        (cmd)
  );

  wire ver_s     = pins_s[3];
  wire supply_s  = pins_s[2];
  wire xtal_s    = pins_s[1];
  wire settled_s = pins_s[0];

  // ------------------------------------------------------------------
  // State, timer and build strap
  // ------------------------------------------------------------------
  rmps_state_t                      state_ff;
  rmps_state_t                      nxt_state;
  logic [rmps_pkg::CNT_W-1:0]       cnt_ff;
  logic [1:0]                       boot_ff;
  logic                             conv_ver_ff;
  logic                             irq_ff;
  rmps_pkg::rmps_pwr_t              pwr_ff;
  rmps_pkg::rmps_pwr_t              nxt_pwr;
  rmps_pkg::rmps_rf_ctl_t           rf_ff;
  rmps_pkg::rmps_rf_ctl_t           nxt_rf;

  // A programmed start time beyond the guaranteed bound is clamped, so
  // a careless setting can never stretch the radio start.
  wire [rmps_pkg::CNT_W-1:0] prog_cyc = rmps_pkg::CNT_W'(
    {9'h0, radio_startup_time_i} * rmps_pkg::CYC_PER_US);
  wire [rmps_pkg::CNT_W-1:0] start_lim = rmps_pkg::CNT_W'(
    rmps_pkg::START_CYC - 1);
  wire [rmps_pkg::CNT_W-1:0] start_cyc =
    (prog_cyc == '0) ? '0 : (prog_cyc - 1'b1);
  wire start_done = (cnt_ff >= start_cyc) || (cnt_ff >= start_lim);
  wire turn_done  = rf_sts_i.pll_lock ||
    (cnt_ff >= rmps_pkg::CNT_W'(rmps_pkg::TURN_CYC - 1));
  wire [rmps_pkg::CNT_W-1:0] wake_lim = conv_ver_ff ?
    rmps_pkg::CNT_W'(XT_STD_CYC - 1) : rmps_pkg::CNT_W'(PD_STD_CYC - 1);
  wire wake_rdy  = xtal_s && (settled_s || !conv_ver_ff);
  wire wake_done = wake_rdy || (cnt_ff >= wake_lim);

  wire cmd_is_tx   = cmd.valid && (cmd.code == rmps_pkg::CMD_TX);
  wire cmd_is_rx   = cmd.valid && (cmd.code == rmps_pkg::CMD_RX);
  wire cmd_is_std  = cmd.valid && (cmd.code == rmps_pkg::CMD_STANDBY);
  wire cmd_is_deep = cmd.valid && (cmd.code == rmps_pkg::CMD_DEEP);
  wire cmd_is_wake = cmd.valid && (cmd.code == rmps_pkg::CMD_WAKE);
  wire cmd_is_bpm  = cmd.valid && (cmd.code == rmps_pkg::CMD_BPM);
  wire started     = (state_ff != ST_BOOT) && (state_ff != ST_RC_RAMP) &&
                     (state_ff != ST_XTAL);

  // ------------------------------------------------------------------
  // Mode sequencing
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BOOT:     if (boot_ff == rmps_pkg::BOOT_CYC) nxt_state = ST_RC_RAMP;
      ST_RC_RAMP:  if (supply_s) nxt_state = ST_XTAL;
      ST_XTAL:     if (xtal_s) nxt_state = ST_STANDBY;
      ST_STANDBY: begin
        if (cmd_is_tx) begin
          nxt_state = ST_TX_START;
        end else if (cmd_is_rx) begin
          nxt_state = ST_RX_START;
        end else if (cmd_is_deep) begin
          nxt_state = ST_DEEP;
        end
      end
      ST_TX_START: if (start_done) nxt_state = ST_TX;
      ST_TX: begin
        if (rf_sts_i.pkt_sent) begin
          nxt_state = auto_ack_i ? ST_TX_TURN : ST_STANDBY;
        end
      end
      ST_TX_TURN:  if (turn_done) nxt_state = ST_TX_ACK;
      ST_TX_ACK:   if (rf_sts_i.ack_done) nxt_state = ST_STANDBY;
      ST_RX_START: if (start_done) nxt_state = ST_RX;
      ST_RX: begin
        if (cmd_is_std) begin
          nxt_state = ST_STANDBY;
        end else if (rf_sts_i.pkt_rcvd && auto_ack_i) begin
          nxt_state = ST_RX_TURN;
        end
      end
      ST_RX_TURN:  if (turn_done) nxt_state = ST_RX_ACK;
      ST_RX_ACK:   if (rf_sts_i.ack_done) nxt_state = ST_RX_BACK;
      ST_RX_BACK:  if (turn_done) nxt_state = ST_RX;
      ST_DEEP:     if (cmd_is_wake) nxt_state = ST_WAKE;
      ST_WAKE:     if (wake_done) nxt_state = ST_STANDBY;
      ST_BPM:      nxt_state = ST_BPM;
      default:     nxt_state = ST_BOOT;
    endcase
    // Battery protection is honoured from any mode once started.
    if (started && cmd_is_bpm) begin
      nxt_state = ST_BPM;
    end
  end

  // ------------------------------------------------------------------
  // Power and radio controls, decoded from the next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_pwr = '0;
    nxt_rf  = '0;
    case (nxt_state)
      ST_BOOT: begin
        nxt_pwr.rc_en = 1'b1;
      end
      ST_RC_RAMP: begin
        nxt_pwr.rc_en = 1'b1;
      end
      ST_XTAL: begin
        nxt_pwr.rc_en   = 1'b1;
        nxt_pwr.xtal_en = 1'b1;
      end
      ST_DEEP: begin
        nxt_pwr.rc_en         = conv_ver_ff;
        nxt_pwr.conv_bangbang = conv_ver_ff;
        nxt_pwr.clk_gate      = !conv_ver_ff;
        nxt_pwr.vdd_low       = !conv_ver_ff;
      end
      ST_WAKE: begin
        nxt_pwr.rc_en         = conv_ver_ff;
        nxt_pwr.conv_bangbang = conv_ver_ff;
        nxt_pwr.xtal_en       = 1'b1;
      end
      ST_BPM: begin
        nxt_pwr.bpm_load = 1'b1;
      end
      default: begin
        // Standby and every radio mode run on the crystal.
        nxt_pwr.xtal_en   = 1'b1;
        nxt_pwr.conv_full = conv_ver_ff;
      end
    endcase
    case (nxt_state)
      ST_TX_START, ST_RX_START, ST_TX_TURN, ST_RX_TURN, ST_RX_BACK: begin
        nxt_rf.en = 1'b1;
      end
      ST_TX, ST_RX_ACK: begin
        nxt_rf = '{en: 1'b1, tx: 1'b1, rx: 1'b0, ready: 1'b1};
      end
      ST_RX, ST_TX_ACK: begin
        nxt_rf = '{en: 1'b1, tx: 1'b0, rx: 1'b1, ready: 1'b1};
      end
      default: nxt_rf = '0;
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_BOOT;
      cnt_ff   <= '0;
      boot_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff) ? '0 : cnt_ff + 1'b1;
      if (state_ff == ST_BOOT) begin
        boot_ff <= boot_ff + 1'b1;
      end
    end
  end

  // The strap is taken once the synchroniser has filled, never at reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_ver_ff <= 1'b0;
    end else if (state_ff == ST_BOOT) begin
      conv_ver_ff <= ver_s;
    end
  end

  // The ready flag stays high through every later mode; a later reset of
  // the core clears it again.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
      pwr_ff <= rmps_pkg::PWR_RST;
      rf_ff  <= '0;
    end else begin
      if (state_ff == ST_XTAL && nxt_state == ST_STANDBY) begin
        irq_ff <= 1'b1;
      end
      pwr_ff <= nxt_pwr;
      rf_ff  <= nxt_rf;
    end
  end

  assign irq_o  = irq_ff;
  assign pwr_o  = pwr_ff;
  assign rf_o   = rf_ff;
  assign mode_o = state_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_turn;
    (state_ff inside {ST_TX_TURN, ST_RX_TURN, ST_RX_BACK}) |->
      cnt_ff < rmps_pkg::CNT_W'(rmps_pkg::TURN_CYC);
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround too long");

  property p_start;
    (state_ff inside {ST_TX_START, ST_RX_START}) |->
      cnt_ff < rmps_pkg::CNT_W'(rmps_pkg::START_CYC);
  endproperty
  a_start: assert property (p_start) else $error("radio start late");

  property p_wake;
    state_ff == ST_WAKE |-> cnt_ff <= wake_lim;
  endproperty
  a_wake: assert property (p_wake) else $error("wake too long");

  property p_ready;
    $rose(irq_ff) |-> state_ff == ST_STANDBY && pwr_ff.xtal_en;
  endproperty
  a_ready: assert property (p_ready) else $error("irq not at ready");

  property p_standby;
    state_ff == ST_STANDBY |-> pwr_ff.xtal_en && !rf_ff.en && !pwr_ff.rc_en;
  endproperty
  a_standby: assert property (p_standby) else $error("standby mix");

  property p_bpm;
    state_ff == ST_BPM |=> state_ff == ST_BPM && pwr_ff.bpm_load
      && !pwr_ff.xtal_en;
  endproperty
  a_bpm: assert property (p_bpm) else $error("left battery guard");

  property p_deep;
    state_ff == ST_DEEP |-> !pwr_ff.xtal_en &&
      (conv_ver_ff ? pwr_ff.conv_bangbang : pwr_ff.clk_gate);
  endproperty
  a_deep: assert property (p_deep) else $error("deep mode wrong");

  property p_txack;
    state_ff == ST_TX && rf_sts_i.pkt_sent && auto_ack_i &&
      !cmd_is_bpm |=> state_ff == ST_TX_TURN ##1 1'b1;
  endproperty
  a_txack: assert property (p_txack) else $error("no ack turn");

  property p_ignore;
    cmd_is_tx && state_ff != ST_STANDBY |=>
      state_ff != ST_TX_START;
  endproperty
  a_ignore: assert property (p_ignore) else $error("tx not ignored");

  property p_rxback;
    state_ff == ST_RX_BACK && turn_done && !cmd_is_bpm |=>
      state_ff == ST_RX && rf_ff.rx && !rf_ff.tx;
  endproperty
  a_rxback: assert property (p_rxback) else $error("no rx return");

endmodule

// *** verification/rmps_host_model.sv ***
`timescale 1ns/100ps
module rmps_host_model (
  input  wire logic                rst_n_i,
  input  wire logic                host_ready_i,
  output logic                     link_clk_o,
  output logic                     host_valid_o,
  output rmps_pkg::rmps_cmd_code_t host_code_o
);
  logic run;
  int   n;

  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  // The link clock stands still between commands, except during reset,
  // so the core must not rely on a free running host clock.
  initial begin
    link_clk_o   = 1'b0;
    run          = 1'b0;
    host_valid_o = 1'b0;
    host_code_o  = rmps_pkg::CMD_NOP;
    #1.3;
    forever begin
      #3;
      if (run || !rst_n_i || link_clk_o) begin
        link_clk_o = ~link_clk_o;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command transfer
  // ----------------------------------------------------------------
  task automatic send(input rmps_pkg::rmps_cmd_code_t c, output bit ok);
    run = 1'b1;
    n   = 0;
    @(posedge link_clk_o);
    host_valid_o <= 1'b1;
    host_code_o  <= c;
    do begin
      @(posedge link_clk_o);
      n++;
    end while (host_ready_i !== 1'b1 && n < 64);
    ok = (host_ready_i === 1'b1);
    // A released code line must not keep showing the old command.
    host_valid_o <= 1'b0;
    host_code_o  <= rmps_pkg::rmps_cmd_code_t'(~c);
    repeat (2) @(posedge link_clk_o);
    n = 0;
    while (host_ready_i !== 1'b1 && n < 64) begin
      @(posedge link_clk_o);
      n++;
    end
    ok  = ok && (host_ready_i === 1'b1);
    run = 1'b0;
  endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  logic                     mclk;
  logic                     rst_n;
  logic                     link_clk;
  logic                     host_valid;
  rmps_pkg::rmps_cmd_code_t host_code;
  logic                     host_ready;
  logic                     conv_version;
  logic                     supply_ok;
  logic                     xtal_ok;
  logic                     conv_settled;
  logic                     auto_ack;
  logic [7:0]               st_time;
  rmps_pkg::rmps_rf_sts_t   rf_sts;
  logic                     irq;
  rmps_pkg::rmps_pwr_t      pwr;
  rmps_pkg::rmps_rf_ctl_t   rf;
  logic [3:0]               mode;
  int                       tests_run = 0;
  int                       miscompares = 0;
  int                       cycles = 0;

  rmps_seq #(.PD_STD_CYC(50), .XT_STD_CYC(50)) uut (
    .mclk_i(mclk), .rst_n_i(rst_n), .link_clk_i(link_clk),
    .host_valid_i(host_valid), .host_code_i(host_code),
    .host_ready_o(host_ready), .conv_version_i(conv_version),
    .supply_ok_i(supply_ok), .xtal_ok_i(xtal_ok),
    .conv_settled_i(conv_settled), .auto_ack_i(auto_ack),
    .radio_startup_time_i(st_time), .rf_sts_i(rf_sts), .irq_o(irq),
    .pwr_o(pwr), .rf_o(rf), .mode_o(mode)
  );

  rmps_host_model host (
    .rst_n_i(rst_n), .host_ready_i(host_ready), .link_clk_o(link_clk),
    .host_valid_o(host_valid), .host_code_o(host_code)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmd(input rmps_pkg::rmps_cmd_code_t c);
    bit ok;
    host.send(c, ok);
    `CHK("link_take", 1'b1, ok)
  endtask

  task automatic wait_mode(input logic [3:0] m, input int lim,
                           input string nm);
    int i;
    i = 0;
    while (mode !== m && i < lim) begin
      @(posedge mclk);
      i++;
    end
    `CHK(nm, m, mode)
  endtask

  task automatic pulse(input rmps_pkg::rmps_rf_sts_t v);
    @(posedge mclk);
    rf_sts <= v;
    @(posedge mclk);
    rf_sts <= '0;
  endtask

  task automatic boot(input logic conv);
    @(posedge mclk);
    rst_n        <= 1'b0;
    conv_version <= conv;
    supply_ok    <= 1'b0;
    xtal_ok      <= 1'b0;
    conv_settled <= 1'b0;
    repeat (10) @(posedge mclk);
    `CHK("rst_pwr", 7'h40, pwr)
    `CHK("rst_irq", 1'b0, irq)
    rst_n <= 1'b1;
    wait_mode(4'h1, 20, "rc_ramp");
    `CHK("ramp_rf", 4'h0, rf)
    `CHK("ramp_xtal", 1'b0, pwr.xtal_en)
    @(posedge mclk);
    supply_ok <= 1'b1;
    wait_mode(4'h2, 20, "xtal");
    `CHK("xtal_en", 1'b1, pwr.xtal_en)
    `CHK("xtal_rc", 1'b1, pwr.rc_en)
    `CHK("xtal_irq", 1'b0, irq)
    @(posedge mclk);
    xtal_ok      <= 1'b1;
    conv_settled <= 1'b1;
    wait_mode(4'h3, 20, "standby");
    `CHK("ready_irq", 1'b1, irq)
    `CHK("stby_pwr", conv ? 7'h30 : 7'h20, pwr)
    $display("test startup done");
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    conv_version = 1'b1;
    supply_ok = 1'b0;
    xtal_ok = 1'b0;
    conv_settled = 1'b0;
    auto_ack = 1'b1;
    st_time = 8'h02;
    rf_sts = '0;
    boot(1'b1);
    cmd(rmps_pkg::CMD_TX);
    wait_mode(4'h4, 20, "tx_start");
    `CHK("tx_en", 1'b1, rf.en)
    repeat (40) @(posedge mclk);
    `CHK("tx_early", 4'h4, mode)
    wait_mode(4'h5, 15, "tx");
    `CHK("tx_state", 1'b1, rf.tx)
    cmd(rmps_pkg::CMD_RX);
    repeat (10) @(posedge mclk);
    `CHK("tx_hold", 4'h5, mode)
    pulse(4'h8);
    wait_mode(4'h6, 5, "tx_turn");
    pulse(4'h1);
    wait_mode(4'h7, 5, "tx_ack");
    `CHK("ack_rx", 1'b1, rf.rx)
    pulse(4'h2);
    wait_mode(4'h3, 5, "tx_done");
    $display("test transmit done");
    st_time <= 8'h00;
    cmd(rmps_pkg::CMD_RX);
    wait_mode(4'h9, 20, "rx");
    `CHK("rx_state", 1'b1, rf.rx)
    pulse(4'h4);
    wait_mode(4'ha, 5, "rx_turn");
    wait_mode(4'hb, 3205, "turn_limit");
    `CHK("ack_tx", 1'b1, rf.tx)
    pulse(4'h2);
    wait_mode(4'hc, 5, "rx_back_turn");
    `CHK("back_rf", 4'h8, rf)
    pulse(4'h1);
    wait_mode(4'h9, 5, "rx_back");
    auto_ack <= 1'b0;
    pulse(4'h4);
    repeat (5) @(posedge mclk);
    `CHK("rx_stay", 4'h9, mode)
    cmd(rmps_pkg::CMD_STANDBY);
    wait_mode(4'h3, 20, "rx_stop");
    cmd(rmps_pkg::CMD_TX);
    wait_mode(4'h5, 20, "tx2");
    pulse(4'h8);
    wait_mode(4'h3, 5, "tx_noack");
    $display("test receive done");
    cmd(rmps_pkg::CMD_DEEP);
    wait_mode(4'hd, 20, "deep");
    `CHK("deep_xtal", 1'b0, pwr.xtal_en)
    `CHK("deep_bb", 1'b1, pwr.conv_bangbang)
    `CHK("deep_rc", 1'b1, pwr.rc_en)
    @(posedge mclk);
    xtal_ok      <= 1'b0;
    conv_settled <= 1'b0;
    cmd(rmps_pkg::CMD_WAKE);
    wait_mode(4'he, 20, "wake");
    @(posedge mclk);
    xtal_ok <= 1'b1;
    wait_mode(4'h3, 60, "wake_limit");
    $display("test deep done");
    cmd(rmps_pkg::CMD_BPM);
    wait_mode(4'hf, 20, "bpm");
    `CHK("bpm_pwr", 7'h01, pwr)
    `CHK("bpm_rf", 4'h0, rf)
    cmd(rmps_pkg::CMD_STANDBY);
    cmd(rmps_pkg::CMD_TX);
    repeat (10) @(posedge mclk);
    `CHK("bpm_stay", 4'hf, mode)
    $display("test protection done");
    boot(1'b0);
    cmd(rmps_pkg::CMD_DEEP);
    wait_mode(4'hd, 20, "pdown");
    `CHK("pd_gate", 1'b1, pwr.clk_gate)
    `CHK("pd_vdd", 1'b1, pwr.vdd_low)
    `CHK("pd_xtal", 1'b0, pwr.xtal_en)
    @(posedge mclk);
    xtal_ok <= 1'b0;
    cmd(rmps_pkg::CMD_WAKE);
    wait_mode(4'he, 20, "pd_wake");
    repeat (20) @(posedge mclk);
    `CHK("pd_wait", 4'he, mode)
    xtal_ok <= 1'b1;
    wait_mode(4'h3, 30, "pd_std");
    $display("test power down done");
    finish_test();
  end
endmodule
